/* File: sld_cfg.svh */
/*
 Named constants of the segment display driver: decode addresses, field
 positions, reset values and drive levels.
 Assumes to be included by its bare name; holds definitions only.
*/
`ifndef SLD_CFG_SVH
`define SLD_CFG_SVH

// ----------
// Display memory window
// ----------
`define SLD_DM_LO     8'h80
`define SLD_DM_HI     8'h9F
`define SLD_DM_PAGE   8'h01
`define SLD_DM_IDXW   5

// ----------
// Control register addresses
// ----------
`define SLD_ADR_CTL0  8'h60
`define SLD_ADR_CTL1  8'h61
`define SLD_ADR_SEL0  8'h62
`define SLD_ADR_SEL1  8'h63
`define SLD_ADR_SEL2  8'h64
`define SLD_ADR_SEL3  8'h65

// ----------
// Fields, masks and reset values
// ----------
`define SLD_EN_BIT    7
`define SLD_TYPE_BIT  6
`define SLD_DUTY_BIT  5
`define SLD_BIAS_BIT  4
`define SLD_RSEL_RNG  2:0
`define SLD_QCT_RNG   7:5
`define SLD_VLCD_RNG  3:0
`define SLD_CTL0_MASK 8'hF7
`define SLD_CTL1_MASK 8'h8F
`define SLD_CTL_RST   8'h00
`define SLD_SEL_RST   8'hFF
`define SLD_MEM_RST   8'h00

// ----------
// Scan and drive levels
// ----------
`define SLD_LAST_COM4 3'h3
`define SLD_LAST_COM8 3'h7
`define SLD_TOP_3     3'h3
`define SLD_TOP_4     3'h4
`define SLD_LVL_UNSEL 3'h1
`define SLD_LVL_OFF   3'h2
`define SLD_LVL_GND   3'h0
`define SLD_QC_ZERO   3'h0

`endif

/* File: sld_pkg.sv */
/*
 Types shared by the segment display driver modules.
 Assumes nothing of its surroundings.
*/
package sld_pkg;

   typedef enum logic [1:0] {
      SLD_RES_OFF   = 2'h0,
      SLD_RES_1170K = 2'h1,
      SLD_RES_225K  = 2'h2,
      SLD_RES_60K   = 2'h3
   } sld_res_t;

   typedef enum logic [1:0] {
      SLD_SC_IDLE = 2'b01,
      SLD_SC_RUN  = 2'b10
   } sld_scan_st_t;

   typedef enum logic [2:0] {
      SLD_QC_IDLE = 3'b001,
      SLD_QC_FAST = 3'b010,
      SLD_QC_HOLD = 3'b100
   } sld_qc_st_t;

   typedef struct packed {
      sld_scan_st_t st;
      logic [2:0]   com;
      logic         half;
      logic         frame;
      logic         change;
   } sld_scan_t;

   typedef struct packed {
      sld_qc_st_t st;
      logic [2:0] cnt;
      sld_res_t   res;
   } sld_charge_t;

   typedef struct packed {
      logic [7:0]       ctl0;
      logic [7:0]       ctl1;
      logic [3:0][7:0]  sel;
      logic [31:0][7:0] mem;
      logic             subS1;
      logic             subS2;
      logic             subPrev;
      logic [7:0]       rdData;
      logic             rdHit;
      logic [7:0][2:0]  comLvl;
      logic [31:0][2:0] segLvl;
   } sld_ctrl_t;

endpackage : sld_pkg

/* File: sld_drv_if.sv */
/*
 Carrier between the control block, the common scanner and the
 quick-charge timer.
 Assumes all three run on core_clk.
*/
`timescale 1ns/1ps
interface sld_drv_if;
   import sld_pkg::*;
   logic       subTick;
   logic       enable;
   logic       typeB;
   logic       duty8;
   logic [2:0] qct;
   logic [2:0] rsel;
   logic       comChange;
   logic [2:0] comIdx;
   logic       polarity;
   sld_res_t   resCode;

   modport ctrl   (output subTick, enable, typeB, duty8, qct, rsel,
                   input comChange, comIdx, polarity, resCode);
   modport scan   (input subTick, enable, typeB, duty8,
                   output comChange, comIdx, polarity);
   modport charge (input subTick, enable, comChange, qct, rsel,
                   output resCode);
endinterface : sld_drv_if

/* File: sld_scan.sv */
/*
 Common scanner: steps through the active commons on sub clock ticks.
 Assumes subTick is a one-cycle pulse per sub clock period.
*/
`timescale 1ns/1ps
`include "sld_cfg.svh"
module sld_scan
   import sld_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Driver link
   sld_drv_if.scan  drv
);

   sld_scan_t  s_q;
   sld_scan_t  s_d;
   logic [2:0] lastCom;

   always_comb begin
      lastCom = drv.duty8 ? `SLD_LAST_COM8 : `SLD_LAST_COM4;
      s_d = s_q;
      s_d.change = 1'b0;
      unique case (s_q.st)
         SLD_SC_IDLE: begin
            s_d.com   = 3'h0;
            s_d.half  = 1'b0;
            s_d.frame = 1'b0;
            if (drv.enable) begin
               s_d.st     = SLD_SC_RUN;
               s_d.change = 1'b1;
            end
         end
         SLD_SC_RUN: begin
            if (!drv.enable) begin
               s_d.st = SLD_SC_IDLE;
            end else if (drv.subTick) begin
               // Type A gives each common both polarities inside its
               // phase; type B flips polarity once per frame.
               s_d.half = !drv.typeB && !s_q.half;
               if (drv.typeB || s_q.half) begin
                  s_d.change = 1'b1;
                  if (s_q.com >= lastCom) begin
                     s_d.com   = 3'h0;
                     s_d.frame = !s_q.frame;
                  end else begin
                     s_d.com = s_q.com + 3'h1;
                  end
               end
            end
         end
         default: s_d.st = SLD_SC_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= '{st: SLD_SC_IDLE, com: 3'h0, half: 1'b0, frame: 1'b0, change: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign drv.comChange = s_q.change;
   assign drv.comIdx    = s_q.com;
   assign drv.polarity  = drv.typeB ? s_q.frame : s_q.half;

endmodule : sld_scan

/* File: sld_charge.sv */
/*
 Bias resistor selection with the timed quick-charge window.
 Assumes comChange pulses once each time the active common changes.
*/
`timescale 1ns/1ps
`include "sld_cfg.svh"
module sld_charge
   import sld_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Driver link
   sld_drv_if.charge drv
);

   sld_charge_t c_q;
   sld_charge_t c_d;
   logic        quick;
   sld_res_t    highRes;

   always_comb begin
      quick   = drv.rsel[2] || (drv.rsel[1] && drv.rsel[0]);
      highRes = drv.rsel[2] ? SLD_RES_225K : SLD_RES_1170K;
      c_d = c_q;
      unique case (c_q.st)
         SLD_QC_IDLE: begin
            if (drv.enable && quick && drv.comChange) begin
               c_d.st  = SLD_QC_FAST;
               c_d.cnt = drv.qct;
            end
         end
         SLD_QC_FAST: begin
            if (!drv.enable || !quick) begin
               c_d.st = SLD_QC_IDLE;
            end else if (drv.comChange) begin
               c_d.cnt = drv.qct;
            end else if (drv.subTick) begin
               if (c_q.cnt == `SLD_QC_ZERO) begin
                  c_d.st = SLD_QC_HOLD;
               end else begin
                  c_d.cnt = c_q.cnt - 3'h1;
               end
            end
         end
         SLD_QC_HOLD: begin
            if (!drv.enable || !quick) begin
               c_d.st = SLD_QC_IDLE;
            end else if (drv.comChange) begin
               c_d.st  = SLD_QC_FAST;
               c_d.cnt = drv.qct;
            end
         end
         default: c_d.st = SLD_QC_IDLE;
      endcase
      if (!drv.enable) begin
         c_d.res = SLD_RES_OFF;
      end else if (!quick) begin
         unique case (drv.rsel[1:0])
            2'h0:    c_d.res = SLD_RES_1170K;
            2'h1:    c_d.res = SLD_RES_225K;
            default: c_d.res = SLD_RES_60K;
         endcase
      end else begin
         c_d.res = (c_d.st == SLD_QC_HOLD) ? highRes : SLD_RES_60K;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         c_q <= '{st: SLD_QC_IDLE, cnt: 3'h0, res: SLD_RES_OFF};
      end else begin
         c_q <= c_d;
      end
   end

   assign drv.resCode = c_q.res;

endmodule : sld_charge

/* File: sld_ctrl.sv */
/*
 Segment display driver control: control registers, pin selectors, the
 display memory window and the common and segment level generation.
 Assumes the core presents one data memory access per cycle with the
 upper indirect pointer byte alongside, and that the sub clock arrives
 as a free-running pin much slower than core_clk.
*/
`timescale 1ns/1ps
`include "sld_cfg.svh"
module sld_ctrl
   import sld_pkg::*;
(
   // Clock and reset
   input  wire logic             core_clk,
   input  wire logic             rst_b,
   // Core data memory access
   input  wire logic [7:0]       dmAddr,
   input  wire logic             dmIndirect,
   input  wire logic [7:0]       indirectPointerHigh,
   input  wire logic             dmWrEn,
   input  wire logic             dmRdEn,
   input  wire logic [7:0]       dmWrData,
   output logic [7:0]            dmRdData,
   output logic                  dmRdHit,
   output logic                  dispSel,
   // Sub clock pin
   input  wire logic             subClockPin,
   // Panel drive
   output logic [7:0][2:0]       comLevel,
   output logic [31:0][2:0]      segLevel,
   output logic [7:0]            comPortMode,
   output logic [31:0]           segmentPinSelect,
   output logic                  biasQuarter,
   output logic [3:0]            driveLevelSelect,
   output sld_res_t              biasResistor,
   output logic                  displayDriveOn
);

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------

   // Level of one pin in steps of the bias fraction; the negative
   // polarity mirrors every level about half the top.
   function automatic logic [2:0] sld_level(input logic extreme,
                                             input logic isCom,
                                             input logic pol,
                                             input logic quarter);
      logic [2:0] top;
      logic [2:0] base;
      top = quarter ? `SLD_TOP_4 : `SLD_TOP_3;
      if (isCom) begin
         base = extreme ? top : `SLD_LVL_UNSEL;
      end else begin
         base = extreme ? `SLD_LVL_GND : `SLD_LVL_OFF;
      end
      return pol ? top - base : base;
   endfunction : sld_level

   function automatic logic sld_addr_is(input logic [7:0] a,
                                        input logic [7:0] ref_a);
      return a == ref_a;
   endfunction : sld_addr_is

   // ----------------------------------------------------------------------
   // State and submodules
   // ----------------------------------------------------------------------
   sld_ctrl_t               r_q;
   sld_ctrl_t               r_d;
   sld_drv_if               drv ();
   logic                    inWindow;
   logic [4:0]              memIdx;
   logic [7:0]              rdMux;
   logic                    rdMapped;
   logic                    activeCom;
   logic [7:0]              wrCtl0;
   logic [7:0]              wrCtl1;

   sld_scan u_scan (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .drv      (drv.scan)
   );

   sld_charge u_charge (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .drv      (drv.charge)
   );

   assign drv.subTick = r_q.subS2 && !r_q.subPrev;
   assign drv.enable  = r_q.ctl0[`SLD_EN_BIT];
   assign drv.typeB   = r_q.ctl0[`SLD_TYPE_BIT];
   assign drv.duty8   = r_q.ctl0[`SLD_DUTY_BIT];
   assign drv.qct     = r_q.ctl1[`SLD_QCT_RNG];
   assign drv.rsel    = r_q.ctl0[`SLD_RSEL_RNG];

   // ----------------------------------------------------------------------
   // Access decode
   // ----------------------------------------------------------------------

   // The window is claimed only for indirect accesses on page 01H; the
   // general RAM outside this block must answer every other 80H-9FH hit.
   assign inWindow = (dmAddr >= `SLD_DM_LO) && (dmAddr <= `SLD_DM_HI);
   assign dispSel  = dmIndirect && inWindow &&
                     (indirectPointerHigh == `SLD_DM_PAGE);
   assign memIdx   = dmAddr[`SLD_DM_IDXW-1:0];
   assign wrCtl0   = dmWrData & `SLD_CTL0_MASK;
   assign wrCtl1   = dmWrData & `SLD_CTL1_MASK;

   always_comb begin
      rdMapped = 1'b1;
      rdMux    = 8'h00;
      if (dispSel) begin
         rdMux = r_q.mem[memIdx];
      end else if (sld_addr_is(dmAddr, `SLD_ADR_CTL0)) begin
         rdMux = r_q.ctl0;
      end else if (sld_addr_is(dmAddr, `SLD_ADR_CTL1)) begin
         rdMux = r_q.ctl1;
      end else if (sld_addr_is(dmAddr, `SLD_ADR_SEL0)) begin
         rdMux = r_q.sel[0];
      end else if (sld_addr_is(dmAddr, `SLD_ADR_SEL1)) begin
         rdMux = r_q.sel[1];
      end else if (sld_addr_is(dmAddr, `SLD_ADR_SEL2)) begin
         rdMux = r_q.sel[2];
      end else if (sld_addr_is(dmAddr, `SLD_ADR_SEL3)) begin
         rdMux = r_q.sel[3];
      end else begin
         rdMapped = 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      r_d = r_q;

      // The sub clock is asynchronous; only the second stage and its delayed copy subPrev feed logic.
      r_d.subS1   = subClockPin;
      r_d.subS2   = r_q.subS1;
      r_d.subPrev = r_q.subS2;

      // Display memory is written only through the window, and the
      // enable bit never touches it, so contents survive a disable.
      if (dmWrEn && dispSel) begin
         r_d.mem[memIdx] = dmWrData;
      end else if (dmWrEn && !inWindow) begin
         if (sld_addr_is(dmAddr, `SLD_ADR_CTL0)) begin
            r_d.ctl0 = wrCtl0;
         end
         if (sld_addr_is(dmAddr, `SLD_ADR_CTL1)) begin
            r_d.ctl1 = wrCtl1;
         end
         if (sld_addr_is(dmAddr, `SLD_ADR_SEL0)) begin
            r_d.sel[0] = dmWrData;
         end
         if (sld_addr_is(dmAddr, `SLD_ADR_SEL1)) begin
            r_d.sel[1] = dmWrData;
         end
         if (sld_addr_is(dmAddr, `SLD_ADR_SEL2)) begin
            r_d.sel[2] = dmWrData;
         end
         if (sld_addr_is(dmAddr, `SLD_ADR_SEL3)) begin
            r_d.sel[3] = dmWrData;
         end
      end

      r_d.rdHit  = dmRdEn && rdMapped;
      r_d.rdData = (dmRdEn && rdMapped) ? rdMux : 8'h00;

      // Commons: selected one at the extreme, others at the unselected
      // level; commons 4-7 fall to port use in quarter duty.
      for (int c = 0; c < 8; c++) begin
         activeCom = drv.duty8 || (c < 4);
         if (!drv.enable || !activeCom) begin
            r_d.comLvl[c] = `SLD_LVL_GND;
         end else begin
            r_d.comLvl[c] = sld_level(drv.comIdx == 3'(c), 1'b1,
                                      drv.polarity,
                                      r_q.ctl0[`SLD_BIAS_BIT]);
         end
      end

      // Segments: byte n of the window feeds segment n, bit c of it
      // the pixel on common c. Fetching is continuous, so a write shows
      // on the next phase without any software step.
      for (int n = 0; n < 32; n++) begin
         if (!drv.enable || r_q.sel[n/8][n%8]) begin
            r_d.segLvl[n] = `SLD_LVL_GND;
         end else begin
            r_d.segLvl[n] = sld_level(r_q.mem[n][drv.comIdx], 1'b0,
                                      drv.polarity,
                                      r_q.ctl0[`SLD_BIAS_BIT]);
         end
      end
   end

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         r_q.ctl0    <= `SLD_CTL_RST;
         r_q.ctl1    <= `SLD_CTL_RST;
         r_q.sel     <= {4{`SLD_SEL_RST}};
         r_q.mem     <= {32{`SLD_MEM_RST}};
         r_q.subS1   <= 1'b0;
         r_q.subS2   <= 1'b0;
         r_q.subPrev <= 1'b0;
         r_q.rdData  <= 8'h00;
         r_q.rdHit   <= 1'b0;
         r_q.comLvl  <= '0;
         r_q.segLvl  <= '0;
      end else begin
         r_q <= r_d;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign dmRdData         = r_q.rdData;
   assign dmRdHit          = r_q.rdHit;
   assign comLevel         = r_q.comLvl;
   assign segLevel         = r_q.segLvl;
   assign comPortMode      = {{4{!r_q.ctl0[`SLD_DUTY_BIT]}}, 4'h0};
   assign segmentPinSelect = r_q.sel;
   assign biasQuarter      = r_q.ctl0[`SLD_BIAS_BIT];
   assign driveLevelSelect = r_q.ctl1[`SLD_VLCD_RNG];
   assign biasResistor     = drv.resCode;
   assign displayDriveOn   = r_q.ctl0[`SLD_EN_BIT];

endmodule : sld_ctrl

/* File: sld_ctrl_properties.sv */
/*
 Assertion checker for the segment display control block.
 Assumes it is bound to sld_ctrl and that all of it runs on core_clk.
*/
`timescale 1ns/1ps
`include "sld_cfg.svh"
module sld_ctrl_properties
   import sld_pkg::*;
(
   // Clock and reset
   input wire logic              core_clk,
   input wire logic              rst_b,
   // Core access
   input wire logic [7:0]        dmAddr,
   input wire logic              dmIndirect,
   input wire logic [7:0]        indirectPointerHigh,
   input wire logic              dmWrEn,
   input wire logic              dmRdEn,
   input wire logic [7:0]        dmWrData,
   input wire logic [7:0]        dmRdData,
   input wire logic              dmRdHit,
   input wire logic              dispSel,
   // Panel drive
   input wire logic [7:0][2:0]   comLevel,
   input wire logic [31:0][2:0]  segLevel,
   input wire logic [7:0]        comPortMode,
   input wire logic [31:0]       segmentPinSelect,
   input sld_res_t               biasResistor,
   input wire logic              displayDriveOn
);
   // ----------
   // Helper state
   // ----------
   logic [31:0] selD1_q;
   logic [31:0] selD2_q;
   logic [7:0]  ctl0_q;
   logic [2:0]  age_q;
   logic        portDrv;
   sld_res_t    resExp;

   // The age counter lets a new resistor code settle before it is judged.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         selD1_q <= 32'hFFFFFFFF;
         selD2_q <= 32'hFFFFFFFF;
         ctl0_q  <= 8'h00;
         age_q   <= 3'h0;
      end else begin
         selD1_q <= segmentPinSelect;
         selD2_q <= selD1_q;
         if (dmWrEn && dmAddr == `SLD_ADR_CTL0) begin
            ctl0_q <= dmWrData;
            age_q  <= 3'h0;
         end else if (age_q != 3'h7) begin
            age_q <= age_q + 3'h1;
         end
      end
   end

   always_comb begin
      portDrv = 1'b0;
      for (int n = 0; n < 32; n++) begin
         portDrv = portDrv | (segmentPinSelect[n] & selD1_q[n] & selD2_q[n] & (|segLevel[n]));
      end
      case (ctl0_q[2:0])
         3'h0:    resExp = SLD_RES_1170K;
         3'h1:    resExp = SLD_RES_225K;
         default: resExp = SLD_RES_60K;
      endcase
   end

   // ----------
   // Properties
   // ----------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   a_window_claimed:
   assert property ((dmWrEn || dmRdEn) && dmIndirect && indirectPointerHigh == 8'h01
                    && dmAddr >= 8'h80 && dmAddr <= 8'h9F |-> dispSel)
      else $error("display window access not claimed");
   a_other_page_free:
   assert property (indirectPointerHigh != 8'h01 |-> !dispSel)
      else $error("display claimed on another page");
   a_direct_free:
   assert property (!dmIndirect |-> !dispSel)
      else $error("display claimed on direct access");
   a_off_levels_zero:
   assert property (!displayDriveOn && !$past(displayDriveOn) && !$past(displayDriveOn, 2)
                    |-> comLevel == '0 && segLevel == '0)
      else $error("levels driven while disabled");
   a_port_com_quiet:
   assert property (comPortMode[4] && $past(comPortMode[4]) && $past(comPortMode[4], 2)
                    |-> comLevel[7:4] == '0)
      else $error("port commons driven");
   a_resistor_code:
   assert property (displayDriveOn && age_q == 3'h7 && ctl0_q[2:0] <= 3'h2 |-> biasResistor == resExp)
      else $error("bias resistor does not match code");
   a_ctl0_gap_zero:
   assert property ($past(dmRdEn) && $past(dmAddr) == `SLD_ADR_CTL0 |-> dmRdHit && !dmRdData[3])
      else $error("control 0 gap bit reads one");
   a_ctl1_gap_zero:
   assert property ($past(dmRdEn) && $past(dmAddr) == `SLD_ADR_CTL1 |-> dmRdHit && dmRdData[6:4] == 3'h0)
      else $error("control 1 gap bits read one");
   a_port_seg_quiet:
   assert property (!portDrv)
      else $error("segment driven in port mode");
endmodule : sld_ctrl_properties

/* File: sld_glass_model.sv */
/*
 Passive glass panel: records every pixel on non-port commons and segments that has seen full drive.
 Assumes level codes in bias steps, sampled on core_clk.
*/
`timescale 1ns/1ps
module sld_glass_model (
   // Clock and clear
   input wire logic              core_clk,
   input wire logic              clr,
   // Drive from the block
   input wire logic [7:0][2:0]   comLevel,
   input wire logic [31:0][2:0]  segLevel,
   input wire logic [7:0]        comPortMode,
   input wire logic [31:0]       segmentPinSelect,
   input wire logic              biasQuarter,
   // Pixels lit since the last clear
   output logic [7:0][31:0]      lit
);
   logic [2:0] top;

   assign top = biasQuarter ? 3'h4 : 3'h3;

   // Partial select voltages stay below the threshold, so only full drive lights a pixel.
   always_ff @(posedge core_clk) begin
      for (int c = 0; c < 8; c++) begin
         for (int s = 0; s < 32; s++) begin
            if (clr) begin
               lit[c][s] <= 1'b0;
            end else if (!comPortMode[c] && !segmentPinSelect[s] && (comLevel[c] - segLevel[s] == top
                         || segLevel[s] - comLevel[c] == top)) begin
               lit[c][s] <= 1'b1;
            end
         end
      end
   end
endmodule : sld_glass_model

/* File: sld_ctrl_tb_top.sv */
/*
 Self-checking bench of the segment display control block.
 Assumes the glass model and the checker are compiled alongside.
*/
`timescale 1ns/1ps
`include "sld_cfg.svh"
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin errors++; $display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end
module sld_ctrl_tb_top
   import sld_pkg::*;
;
   logic             core_clk = 1'b0;
   logic             rst_b = 1'b0;
   logic [7:0]       dmAddr = 8'h00;
   logic             dmIndirect = 1'b0;
   logic [7:0]       indirectPointerHigh = 8'h00;
   logic             dmWrEn = 1'b0;
   logic             dmRdEn = 1'b0;
   logic [7:0]       dmWrData = 8'h00;
   logic             subClockPin = 1'b0;
   logic             clr = 1'b0;
   logic [7:0]       dmRdData;
   logic             dmRdHit;
   logic             dispSel;
   logic [7:0][2:0]  comLevel;
   logic [31:0][2:0] segLevel;
   logic [7:0]       comPortMode;
   logic [31:0]      segmentPinSelect;
   logic             biasQuarter;
   logic [3:0]       driveLevelSelect;
   sld_res_t         biasResistor;
   logic             displayDriveOn;
   logic [7:0][31:0] lit;
   logic [7:0]       rdD;
   logic             rdH;
   logic             rdS;
   logic [3:0]       seen;
   logic [7:0]       expB [32];
   logic [7:0]       cfg [3] = '{8'hA0, 8'hF0, 8'hC0};
   // Each entry: resistor code, charge time code, set of resistors expected.
   logic [9:0]       qtab [7] = '{10'h002, 10'h084, 10'h108, 10'h18A, 10'h20C, 10'h38C, 10'h2F8};
   int               errors = 0;
   int               checks = 0;

   always #10 core_clk = ~core_clk;
   // Sub clock of 20 core periods; its edges fall on core falling edges.
   always #200 subClockPin = ~subClockPin;

   sld_ctrl dut (.*);

   sld_glass_model panel (.*);

   // ----------
   // Access and closing tasks
   // ----------
   task automatic acc(input logic wr, input logic [7:0] a, input logic ind, input logic [7:0] pg,
                      input logic [7:0] wd);
      @(negedge core_clk);
      dmAddr = a;
      dmIndirect = ind;
      indirectPointerHigh = pg;
      dmWrData = wd;
      dmWrEn = wr;
      dmRdEn = !wr;
      #1 rdS = dispSel;
      @(negedge core_clk);
      dmWrEn = 1'b0;
      dmRdEn = 1'b0;
      rdD = dmRdData;
      rdH = dmRdHit;
   endtask : acc

   task automatic finish_test;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : finish_test

   initial begin
      repeat (30000) @(posedge core_clk);
      errors++;
      finish_test();
   end

   // ----------
   // Tests
   // ----------
   // The bench never enables a converter on pins shared with the panel.
   initial begin
      repeat (8) @(posedge core_clk);
      @(negedge core_clk) rst_b = 1'b1;
      for (int i = 0; i < 6; i++) begin
         acc(1'b0, 8'h60 + 8'(i), 1'b0, 8'h00, 8'h00);
         `CHK("reg reset", (i < 2) ? 8'h00 : 8'hFF, rdD)
      end
      `CHK("port mode", 8'hF0, comPortMode)
      acc(1'b1, 8'h60, 1'b0, 8'h00, 8'hFF);
      acc(1'b1, 8'h61, 1'b0, 8'h00, 8'hFF);
      acc(1'b0, 8'h60, 1'b0, 8'h00, 8'h00);
      `CHK("ctl0", 8'hF7, rdD)
      `CHK("enable", 1'b1, displayDriveOn)
      `CHK("bias", 1'b1, biasQuarter)
      acc(1'b0, 8'h61, 1'b0, 8'h00, 8'h00);
      `CHK("ctl1", 8'h8F, rdD)
      `CHK("level select", 4'hF, driveLevelSelect)
      acc(1'b0, 8'h70, 1'b0, 8'h00, 8'h00);
      `CHK("unmapped hit", 1'b0, rdH)
      acc(1'b1, 8'h60, 1'b0, 8'h00, 8'h00);
      $display("test registers done");
      acc(1'b1, 8'h80, 1'b1, 8'h01, 8'h5A);
      `CHK("claim", 1'b1, rdS)
      acc(1'b1, 8'h80, 1'b1, 8'h02, 8'h33);
      `CHK("page 2", 1'b0, rdS)
      acc(1'b1, 8'h80, 1'b0, 8'h01, 8'h33);
      `CHK("direct", 1'b0, rdS)
      acc(1'b0, 8'hA0, 1'b1, 8'h01, 8'h00);
      `CHK("above window", 1'b0, rdS)
      acc(1'b0, 8'h80, 1'b1, 8'h01, 8'h00);
      `CHK("mem kept", 8'h5A, rdD)
      $display("test window done");
      for (int n = 0; n < 32; n++) begin
         expB[n] = (n < 8) ? 8'h01 << n : (n == 31) ? 8'hA5 : 8'h00;
         acc(1'b1, 8'h80 + 8'(n), 1'b1, 8'h01, expB[n]);
      end
      acc(1'b1, 8'h62, 1'b0, 8'h00, 8'h00);
      acc(1'b1, 8'h65, 1'b0, 8'h00, 8'h7F);
      `CHK("selectors", 32'h7FFFFF00, segmentPinSelect)
      for (int k = 0; k < 3; k++) begin
         acc(1'b1, 8'h60, 1'b0, 8'h00, cfg[k]);
         repeat (10) @(negedge core_clk);
         clr = 1'b1;
         @(negedge core_clk) clr = 1'b0;
         repeat (700) @(negedge core_clk);
         for (int c = 0; c < 8; c++) begin
            for (int n = 0; n < 32; n++) begin
               `CHK("pixel", (c < (cfg[k][5] ? 8 : 4)) & expB[n][c], lit[c][n])
            end
         end
      end
      acc(1'b1, 8'h60, 1'b0, 8'h00, 8'h00);
      repeat (5) @(negedge core_clk);
      `CHK("com off", 24'h000000, comLevel)
      acc(1'b0, 8'h9F, 1'b1, 8'h01, 8'h00);
      `CHK("mem after off", 8'hA5, rdD)
      $display("test pixels done");
      for (int q = 0; q < 7; q++) begin
         acc(1'b1, 8'h61, 1'b0, 8'h00, {qtab[q][6:4], 5'h00});
         acc(1'b1, 8'h60, 1'b0, 8'h00, {5'h14, qtab[q][9:7]});
         repeat (300) @(negedge core_clk);
         seen = 4'h0;
         repeat (600) begin
            @(negedge core_clk);
            seen[biasResistor] = 1'b1;
         end
         `CHK("resistors seen", qtab[q][3:0], seen)
      end
      $display("test charge done");
      finish_test();
   end
endmodule : sld_ctrl_tb_top

bind sld_ctrl sld_ctrl_properties u_props (.*);
